// >>> tcpc_pkg.sv
/*
 * Package for the timer, capture and PWM control block.
 * Holds register offsets, bit positions, reset values and state types.
 * Assumes a plain strobe register port on one 125 MHz clock.
 */
package tcpc_pkg;
    localparam logic [3:0] TCPC_ADDR_CTRL   = 4'h0;
    localparam logic [3:0] TCPC_ADDR_CAP2_L = 4'h1;
    localparam logic [3:0] TCPC_ADDR_CAP2_H = 4'h2;
    localparam logic [3:0] TCPC_ADDR_PAIR_L = 4'h3;
    localparam logic [3:0] TCPC_ADDR_PAIR_H = 4'h4;
    localparam logic [3:0] TCPC_ADDR_DDR    = 4'h5;
    localparam logic [3:0] TCPC_ADDR_CNT3_L = 4'h6;
    localparam logic [3:0] TCPC_ADDR_CNT3_H = 4'h7;

    localparam int TCPC_BIT_CAP2_OVF  = 7;
    localparam int TCPC_BIT_CAP1_OVF  = 6;
    localparam int TCPC_BIT_PWM2_EN   = 5;
    localparam int TCPC_BIT_PWM1_EN   = 4;
    localparam int TCPC_BIT_PAIR_MODE = 3;
    localparam int TCPC_BIT_T3_RUN    = 2;
    localparam int TCPC_BIT_T2_RUN    = 1;
    localparam int TCPC_BIT_T1_RUN    = 0;

    localparam logic [7:0] TCPC_CTRL_RESET = 8'h00;
    localparam logic [7:0] TCPC_CTRL_WMASK = 8'h3F;
    localparam logic [1:0] TCPC_DDR_RESET  = 2'h0;

    // Read progress of a two-byte capture pair
    typedef enum logic [1:0] {TCPC_RD_NONE, TCPC_RD_LOW, TCPC_RD_HIGH,
                              TCPC_RD_BOTH} tcpc_rd_t;
endpackage

// >>> tcpc_capture_pair.sv
/*
 * One 16-bit capture register pair with overrun tracking.
 * Assumes capture strobes and read strobes on the same clock.
 */
`timescale 1ns/1ps
module tcpc_capture_pair
    import tcpc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        capture,
    input  wire logic [15:0] count,
    input  wire logic        rd_low,
    input  wire logic        rd_high,
    output logic [15:0]      value_reg,
    output logic             overrun_reg
);
    logic     unread_reg;
    logic     unread_next;
    logic     overrun_next;
    logic     load;
    tcpc_rd_t rd_reg;
    tcpc_rd_t rd_next;
    wire      both_read;

    // A pair counts as read only once both bytes have been fetched
    assign both_read = (rd_reg == TCPC_RD_LOW && rd_high) ||
                       (rd_reg == TCPC_RD_HIGH && rd_low) ||
                       (rd_low && rd_high);
    // Overrun blocks loads until the pair is drained
    assign load = capture && !overrun_reg && !unread_reg;
    // Capture arriving on the draining read still overruns: set wins
    assign overrun_next = (capture && unread_reg) ? 1'b1 :
                          (both_read ? 1'b0 : overrun_reg);
    assign unread_next  = load ? 1'b1 : (both_read ? 1'b0 : unread_reg);

    // Byte read tracker
    always_comb
    begin
        rd_next = rd_reg;
        if (load || both_read)
            rd_next = TCPC_RD_NONE;
        else if (rd_low)
            rd_next = (rd_reg == TCPC_RD_HIGH) ? TCPC_RD_BOTH : TCPC_RD_LOW;
        else if (rd_high)
            rd_next = (rd_reg == TCPC_RD_LOW) ? TCPC_RD_BOTH : TCPC_RD_HIGH;
    end

    // Pair state
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            value_reg   <= 16'h0000;
            overrun_reg <= 1'b0;
            unread_reg  <= 1'b0;
            rd_reg      <= TCPC_RD_NONE;
        end
        else
        begin
            if (load)
                value_reg <= count;
            overrun_reg <= overrun_next;
            unread_reg  <= unread_next;
            rd_reg      <= rd_next;
        end
    end
endmodule

// >>> tcpc_control.sv
/*
 * Timer, capture and PWM control register with its steering logic.
 * Assumes capture pins from outside (synchronised here) and a plain
 * strobe register port on mclk. The third counter lives here, the others elsewhere.
 */
// Function
// - A capture on an unread second pair sets the second overrun flag.
// - After overrun no capture loads until both bytes are read.
// - The shared pair behaves the same, flagged by the first overrun flag.
// - Second PWM enable makes the second pin drive, else direction bit.
// - First PWM enable forces the first pin to drive, else direction bit.
// - Mode select picks capture use or period use of the shared pair.
// - The third timer counts only while its run bit is set.
// - The second timer counts only while its run bit is set.
// - First run bit gates the combined count in sixteen bit mode.
`timescale 1ns/1ps
module tcpc_control
    import tcpc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    input  wire logic       capture1_pin,
    input  wire logic       capture2_pin,
    input  wire logic       sixteen_bit_combine_mode,
    input  wire logic       first_pwm_wave,
    input  wire logic       second_pwm_wave,
    input  wire logic       first_port_data,
    input  wire logic       second_port_data,
    output logic            first_pwm_output_pin_o,
    output logic            first_pwm_output_pin_oe,
    output logic            second_pwm_output_pin_o,
    output logic            second_pwm_output_pin_oe,
    output logic            first_timer_inc,
    output logic            second_timer_inc,
    output logic            third_timer_inc,
    output logic            third_timer_use_period
);
    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_next;
    logic [1:0]  port_direction_bits_reg;
    logic [7:0]  rdata_next;
    logic [15:0] third_timer_count_reg;
    logic [2:0]  cap1_sync_reg;
    logic [2:0]  cap2_sync_reg;
    logic [15:0] second_capture_pair;
    logic [15:0] shared_capture_period_pair;
    logic        cap2_ovf;
    logic        cap1_ovf;
    logic        pair_reg;

    wire cap1_event;
    wire cap2_event;
    wire cap1_enabled;
    wire sel_ctrl;
    wire sel_c2l;
    wire sel_c2h;
    wire sel_pl;
    wire sel_ph;
    wire sel_ddr;

    // Address decode
    assign sel_ctrl = (reg_addr == TCPC_ADDR_CTRL);
    assign sel_c2l  = (reg_addr == TCPC_ADDR_CAP2_L);
    assign sel_c2h  = (reg_addr == TCPC_ADDR_CAP2_H);
    assign sel_pl   = (reg_addr == TCPC_ADDR_PAIR_L);
    assign sel_ph   = (reg_addr == TCPC_ADDR_PAIR_H);
    assign sel_ddr  = (reg_addr == TCPC_ADDR_DDR);

    // Rising edges of the pins, read only past the second stage
    assign cap1_event = cap1_sync_reg[1] && !cap1_sync_reg[2];
    assign cap2_event = cap2_sync_reg[1] && !cap2_sync_reg[2];
    assign cap1_enabled = ctrl_reg[TCPC_BIT_PAIR_MODE];

    // Writable bits only; flags are fed live from the pairs
    assign ctrl_next = (reg_wr && sel_ctrl) ?
                       (reg_wdata & TCPC_CTRL_WMASK) : ctrl_reg;

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        rdata_next = 8'h00;
        if (sel_ctrl)
            rdata_next = {cap2_ovf, cap1_ovf, ctrl_reg[5:0]};
        else if (sel_c2l)
            rdata_next = second_capture_pair[7:0];
        else if (sel_c2h)
            rdata_next = second_capture_pair[15:8];
        else if (sel_pl)
            rdata_next = shared_capture_period_pair[7:0];
        else if (sel_ph)
            rdata_next = shared_capture_period_pair[15:8];
        else if (sel_ddr)
            rdata_next = {6'h00, port_direction_bits_reg};
        else if (reg_addr == TCPC_ADDR_CNT3_L)
            rdata_next = third_timer_count_reg[7:0];
        else if (reg_addr == TCPC_ADDR_CNT3_H)
            rdata_next = third_timer_count_reg[15:8];
    end

    // Register state and synchronisers
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            ctrl_reg                <= TCPC_CTRL_RESET;
            port_direction_bits_reg <= TCPC_DDR_RESET;
            reg_rdata               <= 8'h00;
            cap1_sync_reg           <= 3'h0;
            cap2_sync_reg           <= 3'h0;
            third_timer_count_reg   <= 16'h0000;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            if (reg_wr && sel_ddr)
                port_direction_bits_reg <= reg_wdata[1:0];
            reg_rdata <= reg_rd ? rdata_next : 8'h00;
            cap1_sync_reg <= {cap1_sync_reg[1:0], capture1_pin};
            cap2_sync_reg <= {cap2_sync_reg[1:0], capture2_pin};
            if (ctrl_reg[TCPC_BIT_T3_RUN])
                third_timer_count_reg <= third_timer_count_reg + 16'h0001;
        end
    end

    // Pin steering and timer gates, all from flops
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            first_pwm_output_pin_o   <= 1'b0;
            first_pwm_output_pin_oe  <= 1'b0;
            second_pwm_output_pin_o  <= 1'b0;
            second_pwm_output_pin_oe <= 1'b0;
            first_timer_inc          <= 1'b0;
            second_timer_inc         <= 1'b0;
            third_timer_inc          <= 1'b0;
            third_timer_use_period   <= 1'b1;
            pair_reg                 <= 1'b0;
        end
        else
        begin
            // Direction bit 1 means drive
            first_pwm_output_pin_oe <= ctrl_reg[TCPC_BIT_PWM1_EN] ||
                                       port_direction_bits_reg[0];
            first_pwm_output_pin_o  <= ctrl_reg[TCPC_BIT_PWM1_EN] ?
                                       first_pwm_wave : first_port_data;
            second_pwm_output_pin_oe <= ctrl_reg[TCPC_BIT_PWM2_EN] ||
                                        port_direction_bits_reg[1];
            second_pwm_output_pin_o  <= ctrl_reg[TCPC_BIT_PWM2_EN] ?
                                        second_pwm_wave : second_port_data;
            first_timer_inc  <= ctrl_reg[TCPC_BIT_T1_RUN];
            // Upper byte needs both run bits when combined
            second_timer_inc <= sixteen_bit_combine_mode ?
                                (ctrl_reg[TCPC_BIT_T2_RUN] &&
                                 ctrl_reg[TCPC_BIT_T1_RUN]) :
                                ctrl_reg[TCPC_BIT_T2_RUN];
            third_timer_inc  <= ctrl_reg[TCPC_BIT_T3_RUN];
            third_timer_use_period <= !cap1_enabled;
            pair_reg <= cap1_enabled;
        end
    end

    // Second capture pair
    tcpc_capture_pair u_cap2 (
        .mclk        (mclk),
        .sys_rst     (sys_rst),
        .capture     (cap2_event),
        .count       (third_timer_count_reg),
        .rd_low      (reg_rd && sel_c2l),
        .rd_high     (reg_rd && sel_c2h),
        .value_reg   (second_capture_pair),
        .overrun_reg (cap2_ovf)
    );

    // Shared pair captures only in capture mode
    tcpc_capture_pair u_cap1 (
        .mclk        (mclk),
        .sys_rst     (sys_rst),
        .capture     (cap1_event && pair_reg),
        .count       (third_timer_count_reg),
        .rd_low      (reg_rd && sel_pl),
        .rd_high     (reg_rd && sel_ph),
        .value_reg   (shared_capture_period_pair),
        .overrun_reg (cap1_ovf)
    );
endmodule

// >>> tcpc_checker.sv
/* Checker for the timer, capture and PWM control block.
   Sees only top ports; keeps its own shadow of the control bits. */
`timescale 1ns/1ps
module tcpc_checker
    import tcpc_pkg::*;
(
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       sixteen_bit_combine_mode,
    input wire logic       first_pwm_output_pin_oe,
    input wire logic       second_pwm_output_pin_oe,
    input wire logic       first_timer_inc,
    input wire logic       second_timer_inc,
    input wire logic       third_timer_inc,
    input wire logic       third_timer_use_period
);
    logic [7:0] ctl_reg;
    logic [1:0] ddr_reg;
    logic       run2_exp;

    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // Shadow of writable bits; flags are never written
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            ctl_reg <= TCPC_CTRL_RESET;
            ddr_reg <= TCPC_DDR_RESET;
        end
        else
        begin
            if (reg_wr && reg_addr == TCPC_ADDR_CTRL)
                ctl_reg <= reg_wdata & TCPC_CTRL_WMASK;
            if (reg_wr && reg_addr == TCPC_ADDR_DDR)
                ddr_reg <= reg_wdata[1:0];
        end
    end

    // Upper byte counts only with the lower run bit in 16-bit mode
    assign run2_exp = ctl_reg[TCPC_BIT_T2_RUN] &
                      (~sixteen_bit_combine_mode | ctl_reg[TCPC_BIT_T1_RUN]);

    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    a_unmapped_read_zero: assert property (reg_rd && reg_addr > 4'h7 |=>
        reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_ctrl_read_back: assert property (
        reg_rd && reg_addr == TCPC_ADDR_CTRL |=>
        (reg_rdata & TCPC_CTRL_WMASK) == ($past(ctl_reg) & TCPC_CTRL_WMASK))
        else $error("control read back wrong");
    a_third_run_gate: assert property (
        third_timer_inc == $past(ctl_reg[TCPC_BIT_T3_RUN]))
        else $error("third timer enable wrong");
    a_second_run_gate: assert property (
        second_timer_inc == $past(run2_exp))
        else $error("second timer enable wrong");
    a_first_run_gate: assert property (
        first_timer_inc == $past(ctl_reg[TCPC_BIT_T1_RUN]))
        else $error("first timer enable wrong");
    a_pair_period_use: assert property (
        third_timer_use_period != $past(ctl_reg[TCPC_BIT_PAIR_MODE]))
        else $error("shared pair use wrong");
    a_pwm1_drives_pin: assert property (
        $past(ctl_reg[TCPC_BIT_PWM1_EN]) |-> first_pwm_output_pin_oe)
        else $error("first pin not driven");
    a_pwm2_drives_pin: assert property (
        $past(ctl_reg[TCPC_BIT_PWM2_EN]) |-> second_pwm_output_pin_oe)
        else $error("second pin not driven");
    a_pin1_dir_follow: assert property (
        !$past(ctl_reg[TCPC_BIT_PWM1_EN]) |->
        first_pwm_output_pin_oe == $past(ddr_reg[0]))
        else $error("first pin direction wrong");
    a_pin2_dir_follow: assert property (
        !$past(ctl_reg[TCPC_BIT_PWM2_EN]) |->
        second_pwm_output_pin_oe == $past(ddr_reg[1]))
        else $error("second pin direction wrong");

    c_ctrl_write: cover property (reg_wr && reg_addr == TCPC_ADDR_CTRL);
    c_combined_run: cover property (second_timer_inc &&
        sixteen_bit_combine_mode);
    c_overrun_seen: cover property (reg_rdata[7] || reg_rdata[6]);
endmodule

bind tcpc_control tcpc_checker chk_i (.mclk(mclk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sixteen_bit_combine_mode(sixteen_bit_combine_mode),
    .first_pwm_output_pin_oe(first_pwm_output_pin_oe),
    .second_pwm_output_pin_oe(second_pwm_output_pin_oe),
    .first_timer_inc(first_timer_inc), .second_timer_inc(second_timer_inc),
    .third_timer_inc(third_timer_inc),
    .third_timer_use_period(third_timer_use_period));

// >>> testbench.sv
/* Self-checking bench for the control block.
   Drives the register port and capture pins directly, one clock. */
`timescale 1ns/1ps
module testbench
    import tcpc_pkg::*;
;
    logic       mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic       mode = 1'b0, cap1 = 1'b0, cap2 = 1'b0;
    logic       wave1 = 1'b1, wave2 = 1'b1, pdat1 = 1'b0, pdat2 = 1'b0;
    logic       o1, oe1, o2, oe2, inc1, inc2, inc3, per;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, v, lo, hi, cl, ch;
    int errors = 0, compares = 0;

    tcpc_control dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .capture1_pin(cap1), .capture2_pin(cap2),
        .sixteen_bit_combine_mode(mode), .first_pwm_wave(wave1),
        .second_pwm_wave(wave2), .first_port_data(pdat1),
        .second_port_data(pdat2), .first_pwm_output_pin_o(o1),
        .first_pwm_output_pin_oe(oe1), .second_pwm_output_pin_o(o2),
        .second_pwm_output_pin_oe(oe2), .first_timer_inc(inc1),
        .second_timer_inc(inc2), .third_timer_inc(inc3),
        .third_timer_use_period(per));

    // Clock, 8 ns period
    always #4 mclk = ~mclk;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask

    // Pin goes through a two-flop sync before the edge is seen
    task automatic pulse(input bit second);
        @(posedge mclk);
        if (second)
            cap2 <= 1'b1;
        else
            cap1 <= 1'b1;
        repeat (2) @(posedge mclk);
        cap1 <= 1'b0;
        cap2 <= 1'b0;
        repeat (5) @(posedge mclk);
    endtask

    task automatic settle();
        repeat (2) @(negedge mclk);
    endtask

    task automatic t_ctrl();
        rd(TCPC_ADDR_CTRL, v);
        chk(v, 8'h00);
        chk({5'h0, per, inc3, oe1}, 8'h04);
        wr(TCPC_ADDR_CTRL, 8'hFF);
        rd(TCPC_ADDR_CTRL, v);
        chk(v, 8'h3F);
        chk({2'h0, oe1, oe2, inc1, inc2, inc3, per}, 8'h3E);
        chk({6'h0, o1, o2}, 8'h03);
        wr(TCPC_ADDR_CTRL, 8'h02);
        mode <= 1'b1;
        settle();
        chk({6'h0, inc1, inc2}, 8'h00);
        wr(TCPC_ADDR_CTRL, 8'h03);
        settle();
        chk({6'h0, inc1, inc2}, 8'h03);
        wr(TCPC_ADDR_CTRL, 8'h02);
        mode <= 1'b0;
        settle();
        chk({6'h0, inc1, inc2}, 8'h01);
        wr(TCPC_ADDR_CTRL, 8'h00);
        settle();
        chk({4'h0, inc1, inc2, inc3, per}, 8'h01);
        wr(4'h9, 8'hFF);
        rd(4'h8, v);
        chk(v, 8'h00);
        rd(TCPC_ADDR_CTRL, v);
        chk(v, 8'h00);
    endtask

    // Direction bits steer the pins unless a PWM enable overrides them
    task automatic t_pins();
        wr(TCPC_ADDR_DDR, 8'hFD);
        wave1 <= 1'b0;
        pdat1 <= 1'b1;
        rd(TCPC_ADDR_DDR, v);
        chk(v, 8'h01);
        chk({4'h0, oe1, oe2, o1, o2}, 8'h0A);
        wr(TCPC_ADDR_DDR, 8'h00);
        wr(TCPC_ADDR_CTRL, 8'h30);
        settle();
        chk({4'h0, oe1, oe2, o1, o2}, 8'h0D);
        wr(TCPC_ADDR_CTRL, 8'h00);
        settle();
        chk({4'h0, oe1, oe2, o1, o2}, 8'h02);
    endtask

    // Period use: capture on the shared pair must not load
    task automatic t_mode0();
        wr(TCPC_ADDR_CTRL, 8'h04);
        rd(TCPC_ADDR_CNT3_L, cl);
        rd(TCPC_ADDR_CNT3_L, v);
        chk({7'h0, v !== cl}, 8'h01);
        pulse(0);
        pulse(0);
        rd(TCPC_ADDR_PAIR_L, v);
        chk(v, 8'h00);
        rd(TCPC_ADDR_CTRL, v);
        chk(v, 8'h04);
    endtask

    // Load while running, freeze, overrun twice, drain, reload
    task automatic t_capture(input bit second);
        logic [3:0] al;
        al = second ? TCPC_ADDR_CAP2_L : TCPC_ADDR_PAIR_L;
        wr(TCPC_ADDR_CTRL, 8'h0C);
        pulse(second);
        wr(TCPC_ADDR_CTRL, 8'h08);
        rd(TCPC_ADDR_CNT3_L, cl);
        rd(TCPC_ADDR_CNT3_H, ch);
        rd(TCPC_ADDR_CNT3_L, v);
        chk(v, cl);
        pulse(second);
        pulse(second);
        rd(TCPC_ADDR_CTRL, v);
        chk(v, second ? 8'h88 : 8'h48);
        wr(TCPC_ADDR_CTRL, 8'h08);
        rd(TCPC_ADDR_CTRL, v);
        chk(v, second ? 8'h88 : 8'h48);
        rd(al, lo);
        rd(al + 4'h1, hi);
        chk({7'h0, {hi, lo} !== {ch, cl}}, 8'h01);
        rd(TCPC_ADDR_CTRL, v);
        chk(v, 8'h08);
        pulse(second);
        rd(al, lo);
        rd(al + 4'h1, hi);
        chk(lo, cl);
        chk(hi, ch);
    endtask

    task automatic complete_run();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence after four reset cycles
    initial
    begin
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        t_ctrl();
        t_pins();
        t_mode0();
        t_capture(1);
        t_capture(0);
        complete_run();
    end

    // Watchdog, far beyond the few hundred cycles needed
    initial
    begin
        #100000;
        errors++;
        complete_run();
    end
endmodule
